//--- adcseq_pkg.sv
`default_nettype none
package adcseq_pkg;
  // Conversion length in conversion-clock periods
  localparam logic [3:0] CONV_PERIODS = 4'hd;
  // Falls counted before the half period that marks a late abort
  localparam logic [3:0] LATE_FALLS = 4'hc;
  // Control word width and field positions
  localparam int CTL_W = 12;
  localparam int CTL_RANGE_BIT = 0;
  localparam int CTL_SEQ_BIT = 1;
  localparam int CTL_CODING_BIT = 2;
  localparam int CTL_MASK_ACCESS_BIT_BIT = 3;
  localparam int CTL_PM_LSB = 4;
  localparam int CTL_MODE_LSB = 6;
  localparam int CTL_ADD_LSB = 8;
  localparam int MASK_W = 8;
  // Values after reset
  localparam logic [11:0] CTL_RESET = 12'h000;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  // Channel masks for pair modes and the seven-input pseudo mode
  localparam logic [7:0] PAIR_LEAD_MASK = 8'h55;
  localparam logic [7:0] PSEUDO7_MASK = 8'h7f;
  // Sequencer command held in the {sequence, mask access} bit pair
  typedef enum logic [1:0] {
    SS_OFF = 2'b00,
    SS_LOAD = 2'b01,
    SS_KEEP = 2'b10,
    SS_CONSEC = 2'b11
  } adcseq_cmd_t;
  // Input arrangement, field bit 0 is the first mode bit
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_PSEUDO4 = 2'b01,
    MODE_DIFF = 2'b10,
    MODE_PSEUDO7 = 2'b11
  } adcseq_mode_t;
  // Power states, field bit 1 is the upper power bit
  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_AUTO_SHUTDOWN = 2'b01,
    PM_AUTO_STANDBY = 2'b10,
    PM_FULL_SHUTDOWN = 2'b11
  } adcseq_pm_t;
  // Sequencer states
  typedef enum logic [1:0] {
    SQ_OFF = 2'b00,
    SQ_MASK = 2'b01,
    SQ_CONSEC = 2'b10
  } adcseq_sq_t;
  // Conversion timer states
  typedef enum logic [0:0] {
    CT_IDLE = 1'b0,
    CT_RUN = 1'b1
  } adcseq_ct_t;
endpackage : adcseq_pkg
`default_nettype wire

//--- adcseq_conv_if.sv
`default_nettype none
interface adcseq_conv_if;
  logic start;
  logic clk_rise;
  logic clk_fall;
  logic busy;
  logic done;
  logic aborted;
  logic late_abort;
  modport ctrl (output start, output clk_rise, output clk_fall,
    input busy, input done, input aborted, input late_abort);
  modport timer (input start, input clk_rise, input clk_fall,
    output busy, output done, output aborted, output late_abort);
endinterface : adcseq_conv_if
`default_nettype wire

//--- adcseq_conv_timer.sv
`default_nettype none
module adcseq_conv_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link to the sequencer
  adcseq_conv_if.timer cv
);
  adcseq_pkg::adcseq_ct_t st_q, st_d;
  logic [3:0] falls_q, falls_d;
  logic half_q, half_d;
  logic done_q, done_d;
  logic abort_q, abort_d;
  logic late_q, late_d;

  // Count conversion-clock falls; a new start mid-run aborts the old one
  always_comb
  begin
    st_d = st_q;
    falls_d = falls_q;
    half_d = half_q;
    done_d = 1'b0;
    abort_d = 1'b0;
    late_d = 1'b0;
    if (cv.start)
    begin
      if (st_q == adcseq_pkg::CT_RUN)
      begin
        abort_d = 1'b1; // R2
        late_d = half_q; // R3
      end
      st_d = adcseq_pkg::CT_RUN;
      falls_d = 4'h0;
      half_d = 1'b0;
    end
    else if (st_q == adcseq_pkg::CT_RUN)
    begin
      if (cv.clk_rise && falls_q == adcseq_pkg::LATE_FALLS)
        half_d = 1'b1;
      if (cv.clk_fall)
      begin
        falls_d = falls_q + 4'h1;
        // Only the thirteenth full period releases a result
        if (falls_q == adcseq_pkg::CONV_PERIODS - 4'h1)
        begin
          done_d = 1'b1; // R1
          st_d = adcseq_pkg::CT_IDLE;
          falls_d = 4'h0;
          half_d = 1'b0;
        end
      end
    end
  end

  // Timer registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= adcseq_pkg::CT_IDLE;
      falls_q <= 4'h0;
      half_q <= 1'b0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      late_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      falls_q <= falls_d;
      half_q <= half_d;
      done_q <= done_d;
      abort_q <= abort_d;
      late_q <= late_d;
    end
  end

  assign cv.busy = (st_q == adcseq_pkg::CT_RUN);
  assign cv.done = done_q;
  assign cv.aborted = abort_q;
  assign cv.late_abort = late_q;
endmodule : adcseq_conv_timer
`default_nettype wire

//--- adcseq_top.sv
// How it works
// R1 - A conversion completes only after thirteen full conversion-clock periods.
// R2 - A conversion given fewer than thirteen periods is aborted.
// R3 - After a late abort, host gives start rise or clock fall before writing.
// R4 - Eight-bit write-only mask loads bus bits 0-7 on write strobe rise.
// R5 - Mask write lands only if previous control write chose sequence 0, access 1.
// R6 - Mask bit n selects input channel n; bit 7 is channel 7.
// R7 - Host sets one bit per channel, or both bits per pair.
// R8 - Each start advances to next selected channel upward, wrapping from lowest.
// R9 - Sequence runs until a control write other than sequence 1, access 0.
// R10 - Pair modes convert each pair once, never the swapped polarity.
// R11 - Both bits zero: sequencer off, channel comes from the address field.
// R12 - Sequence 0, access 1 routes next write into the mask, then runs.
// R13 - Sequence 1, access 0 updates fields without disturbing the sequence.
// R14 - Both bits one: convert channels 0 up to the address field, repeat.
// R15 - Result coded straight binary or twos complement by the coding bit.
// R16 - Twelve-bit result, one code per reference span over 4096.
// R17 - Span bit selects zero to reference or zero to twice reference.
// R18 - Power field: normal, auto-shutdown, auto-standby, full shutdown.
// R19 - Input field selects arrangement; first bit 0, second 1 is differential.
// R20 - Without the access condition, a write is a control write only.
`default_nettype none
module adcseq_top (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Processor bus
  input wire logic conversion_start_n,
  input wire logic write_n,
  input wire logic [11:0] data_bus_bits,
  // Converter clock and front end
  input wire logic conversion_clock_in,
  input wire logic [11:0] sample_code,
  // Conversion results
  output logic [11:0] conv_result_q,
  output logic [2:0] result_channel_q,
  output logic result_valid_q,
  output logic conv_busy_q,
  output logic conv_aborted_q,
  output logic [2:0] active_channel_q,
  // Control state seen by the analog side
  output logic span_double_q,
  output logic twos_comp_q,
  output logic [1:0] power_state_q,
  output logic [1:0] input_config_q,
  output logic power_down_q,
  output logic seq_guard_miss_q
);
  // Next channel above cur in mask m, wrapping to the lowest set bit
  function automatic logic [2:0] pick_next(input logic [7:0] m, input logic [2:0] cur,
    input logic from_low);
    logic [2:0] r;
    logic found;
    r = cur;
    found = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (!found && m[i] && (from_low || i > int'(cur)))
      begin
        r = 3'(i);
        found = 1'b1;
      end
    end
    for (int i = 0; i < 8; i++)
    begin
      if (!found && m[i])
      begin
        r = 3'(i);
        found = 1'b1;
      end
    end
    return r;
  endfunction : pick_next

  // Channels allowed as positive input under the given arrangement
  function automatic logic [7:0] usable(input logic [7:0] m, input logic [1:0] mode);
    logic [7:0] r;
    r = m;
    if (mode == adcseq_pkg::MODE_DIFF || mode == adcseq_pkg::MODE_PSEUDO4)
      r = m & adcseq_pkg::PAIR_LEAD_MASK & {1'b0, m[7:1]}; // R10
    else if (mode == adcseq_pkg::MODE_PSEUDO7)
      r = m & adcseq_pkg::PSEUDO7_MASK;
    return r;
  endfunction : usable

  // Reset release through two flops
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Edge detection on the bus strobes and the conversion clock
  logic cs_prev_q, wr_prev_q, ck_prev_q;
  logic cs_fall, cs_rise, wr_rise, ck_rise, ck_fall;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      ck_prev_q <= 1'b0;
    end
    else
    begin
      cs_prev_q <= conversion_start_n;
      wr_prev_q <= write_n;
      ck_prev_q <= conversion_clock_in;
    end
  end
  assign cs_fall = cs_prev_q && !conversion_start_n;
  assign cs_rise = !cs_prev_q && conversion_start_n;
  assign wr_rise = !wr_prev_q && write_n; // R4
  assign ck_rise = !ck_prev_q && conversion_clock_in;
  assign ck_fall = ck_prev_q && !conversion_clock_in;

  // Conversion timer
  adcseq_conv_if cv ();
  assign cv.start = cs_fall;
  assign cv.clk_rise = ck_rise;
  assign cv.clk_fall = ck_fall;
  adcseq_conv_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .cv(cv)
  );

  // Control fields, mask and sequencer state
  logic [11:0] ctl_q, ctl_d;
  logic [7:0] mask_q, mask_d;
  logic arm_q, arm_d;
  adcseq_pkg::adcseq_sq_t sq_q, sq_d;
  logic [2:0] chan_q, chan_d;
  logic first_q, first_d;
  logic unsafe_q, unsafe_d;
  logic miss_d;
  logic [11:0] held_q, held_d;
  logic [2:0] conv_chan_q, conv_chan_d;
  logic [1:0] cmd;
  logic [2:0] addr;
  logic [7:0] seq_mask;
  logic [7:0] consec_mask;

  assign cmd = {data_bus_bits[adcseq_pkg::CTL_SEQ_BIT], data_bus_bits[adcseq_pkg::CTL_MASK_ACCESS_BIT_BIT]};
  assign addr = ctl_q[adcseq_pkg::CTL_ADD_LSB +: 3];

  // Consecutive mode walks channel 0 through the address field
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      consec_mask[i] = (i <= int'(addr)); // R14
  end
  assign seq_mask = usable((sq_q == adcseq_pkg::SQ_CONSEC) ? consec_mask : mask_q,
    ctl_q[adcseq_pkg::CTL_MODE_LSB +: 2]);

  // Starts pick the channel first, then writes override the sequence state
  always_comb
  begin
    ctl_d = ctl_q;
    mask_d = mask_q;
    arm_d = arm_q;
    sq_d = sq_q;
    chan_d = chan_q;
    first_d = first_q;
    held_d = held_q;
    conv_chan_d = conv_chan_q;
    miss_d = 1'b0;
    unsafe_d = unsafe_q;
    // Guard against reprogramming while the sequencer is out of step
    if (cs_rise || ck_fall)
      unsafe_d = 1'b0;
    if (cv.late_abort)
      unsafe_d = 1'b1; // R3
    if (cs_fall)
    begin
      held_d = sample_code;
      if (sq_q == adcseq_pkg::SQ_OFF)
        conv_chan_d = addr; // R11
      else
      begin
        conv_chan_d = pick_next(seq_mask, chan_q, first_q); // R8 R6
        chan_d = conv_chan_d;
        first_d = 1'b0;
      end
    end
    if (wr_rise)
    begin
      miss_d = unsafe_q;
      if (arm_q)
      begin
        mask_d = data_bus_bits[adcseq_pkg::MASK_W-1:0]; // R5 R12
        arm_d = 1'b0;
        sq_d = adcseq_pkg::SQ_MASK;
        first_d = 1'b1;
      end
      else
      begin
        // Ordinary control write, mask left alone
        ctl_d[adcseq_pkg::CTL_RANGE_BIT] = data_bus_bits[adcseq_pkg::CTL_RANGE_BIT]; // R20
        ctl_d[adcseq_pkg::CTL_CODING_BIT] = data_bus_bits[adcseq_pkg::CTL_CODING_BIT];
        ctl_d[adcseq_pkg::CTL_PM_LSB +: 2] = data_bus_bits[adcseq_pkg::CTL_PM_LSB +: 2];
        ctl_d[adcseq_pkg::CTL_MODE_LSB +: 2] = data_bus_bits[adcseq_pkg::CTL_MODE_LSB +: 2];
        ctl_d[adcseq_pkg::CTL_SEQ_BIT] = data_bus_bits[adcseq_pkg::CTL_SEQ_BIT];
        ctl_d[adcseq_pkg::CTL_MASK_ACCESS_BIT_BIT] = data_bus_bits[adcseq_pkg::CTL_MASK_ACCESS_BIT_BIT];
        case (cmd)
          adcseq_pkg::SS_OFF:
          begin
            sq_d = adcseq_pkg::SQ_OFF; // R9 R11
            ctl_d[adcseq_pkg::CTL_ADD_LSB +: 3] = data_bus_bits[adcseq_pkg::CTL_ADD_LSB +: 3];
          end
          adcseq_pkg::SS_LOAD:
          begin
            sq_d = adcseq_pkg::SQ_OFF; // R9
            arm_d = 1'b1; // R12
          end
          adcseq_pkg::SS_KEEP:
          begin
            sq_d = sq_q; // R13
          end
          adcseq_pkg::SS_CONSEC:
          begin
            sq_d = adcseq_pkg::SQ_CONSEC; // R14
            first_d = 1'b1;
            ctl_d[adcseq_pkg::CTL_ADD_LSB +: 3] = data_bus_bits[adcseq_pkg::CTL_ADD_LSB +: 3];
          end
          default:
          begin
            sq_d = sq_q;
          end
        endcase
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_q <= adcseq_pkg::CTL_RESET;
      mask_q <= adcseq_pkg::MASK_RESET;
      arm_q <= 1'b0;
      sq_q <= adcseq_pkg::SQ_OFF;
      chan_q <= adcseq_pkg::CHAN_RESET;
      first_q <= 1'b1;
      unsafe_q <= 1'b0;
      held_q <= 12'h000;
      conv_chan_q <= adcseq_pkg::CHAN_RESET;
    end
    else
    begin
      ctl_q <= ctl_d;
      mask_q <= mask_d;
      arm_q <= arm_d;
      sq_q <= sq_d;
      chan_q <= chan_d;
      first_q <= first_d;
      unsafe_q <= unsafe_d;
      held_q <= held_d;
      conv_chan_q <= conv_chan_d;
    end
  end

  // Output next values; the result only moves when the timer reports done
  logic [11:0] res_d;
  logic [2:0] rch_d;
  logic pd_d;
  logic [1:0] pm;
  assign pm = ctl_q[adcseq_pkg::CTL_PM_LSB +: 2];
  always_comb
  begin
    res_d = conv_result_q;
    rch_d = result_channel_q;
    if (cv.done)
    begin
      // Twos complement is offset binary with the top bit flipped
      if (ctl_q[adcseq_pkg::CTL_CODING_BIT])
        res_d = {~held_q[11], held_q[10:0]}; // R15 R16
      else
        res_d = held_q; // R15
      rch_d = conv_chan_q;
    end
    case (pm)
      adcseq_pkg::PM_NORMAL: pd_d = 1'b0; // R18
      adcseq_pkg::PM_AUTO_SHUTDOWN: pd_d = !cv.busy; // R18
      adcseq_pkg::PM_AUTO_STANDBY: pd_d = !cv.busy; // R18
      adcseq_pkg::PM_FULL_SHUTDOWN: pd_d = 1'b1; // R18
      default: pd_d = 1'b0;
    endcase
  end

  // Output registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_result_q <= 12'h000;
      result_channel_q <= adcseq_pkg::CHAN_RESET;
      result_valid_q <= 1'b0;
      conv_busy_q <= 1'b0;
      conv_aborted_q <= 1'b0;
      active_channel_q <= adcseq_pkg::CHAN_RESET;
      span_double_q <= 1'b0;
      twos_comp_q <= 1'b0;
      power_state_q <= 2'b00;
      input_config_q <= 2'b00;
      power_down_q <= 1'b0;
      seq_guard_miss_q <= 1'b0;
    end
    else
    begin
      conv_result_q <= res_d;
      result_channel_q <= rch_d;
      result_valid_q <= cv.done; // R1
      conv_busy_q <= cv.busy;
      conv_aborted_q <= cv.aborted; // R2
      active_channel_q <= conv_chan_q;
      span_double_q <= ctl_q[adcseq_pkg::CTL_RANGE_BIT]; // R17
      twos_comp_q <= ctl_q[adcseq_pkg::CTL_CODING_BIT];
      power_state_q <= pm;
      input_config_q <= ctl_q[adcseq_pkg::CTL_MODE_LSB +: 2]; // R19
      power_down_q <= pd_d;
      seq_guard_miss_q <= miss_d; // R3
    end
  end
endmodule : adcseq_top
`default_nettype wire

//--- adcseq_top_checker.sv
`default_nettype none
module adcseq_top_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Host side
  input wire logic conversion_start_n,
  input wire logic write_n,
  input wire logic [11:0] data_bus_bits,
  input wire logic conversion_clock_in,
  // Results and control fields
  input wire logic [11:0] conv_result_q,
  input wire logic result_valid_q,
  input wire logic conv_busy_q,
  input wire logic conv_aborted_q,
  input wire logic span_double_q,
  input wire logic twos_comp_q,
  input wire logic [1:0] power_state_q,
  input wire logic [1:0] input_config_q,
  input wire logic power_down_q
);
  // Edge history {start, write, clock}, falls since start, mask-arm flag
  logic [2:0] prev_q;
  logic [2:0] prev_d;
  logic [3:0] falls_q;
  logic [3:0] falls_d;
  logic armed_q;
  logic armed_d;
  always_comb
  begin
    prev_d = {conversion_start_n, write_n, conversion_clock_in};
    falls_d = falls_q;
    armed_d = armed_q;
    if (prev_q[2] && !conversion_start_n)
      falls_d = 4'h0;
    else if (prev_q[0] && !conversion_clock_in && falls_q != 4'hf)
      falls_d = falls_q + 4'h1; // Saturates so a long clock burst cannot wrap
    if (!prev_q[1] && write_n)
      armed_d = !armed_q && !data_bus_bits[1] && data_bus_bits[3];
  end
  // Same idle levels as the design's edge detectors
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prev_q <= 3'h6;
      falls_q <= 4'h0;
      armed_q <= 1'b0;
    end
    else
    begin
      prev_q <= prev_d;
      falls_q <= falls_d;
      armed_q <= armed_d;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // A write in the same cycle wins over a start
  sequence start_seen;
    $fell(conversion_start_n) && !$rose(write_n);
  endsequence
  // A write that is not the mask load after an arm
  sequence ctl_write;
    $rose(write_n) && !armed_q;
  endsequence
  AST_BUSY_AFTER_START: assert property (start_seen |-> ##2 conv_busy_q)
    else $error("busy missing after start");
  AST_ABORT_ON_RESTART: assert property (start_seen ##0 conv_busy_q |-> ##[1:3] conv_aborted_q)
    else $error("restart did not abort");
  AST_DONE_AFTER_13: assert property (conv_busy_q && falls_q == 4'hc &&
    $fell(conversion_clock_in) |-> ##2 result_valid_q)
    else $error("no result after thirteenth period");
  AST_VALID_NEEDS_13: assert property (result_valid_q |-> falls_q == 4'hd && !conv_busy_q)
    else $error("result without thirteen periods");
  AST_RESULT_HOLDS: assert property ($changed(conv_result_q) |-> result_valid_q)
    else $error("result moved without done");
  // Fields land in the control word at the taking edge and show one edge later
  AST_CODING_FIELD: assert property (ctl_write |-> ##2
    twos_comp_q == $past(data_bus_bits[2], 2) && span_double_q == $past(data_bus_bits[0], 2))
    else $error("coding or span field wrong");
  AST_POWER_FIELD: assert property (ctl_write |-> ##2
    power_state_q == $past(data_bus_bits[5:4], 2) && input_config_q == $past(data_bus_bits[7:6], 2))
    else $error("power or input field wrong");
  AST_SHUTDOWN_LEVEL: assert property (power_state_q == 2'h3 [*2] |-> power_down_q)
    else $error("full shutdown not powered down");
endmodule : adcseq_top_checker
bind adcseq_top adcseq_top_checker adcseq_top_checker_i (.clk(clk), .nrst(nrst),
  .conversion_start_n(conversion_start_n), .write_n(write_n), .data_bus_bits(data_bus_bits),
  .conversion_clock_in(conversion_clock_in), .conv_result_q(conv_result_q),
  .result_valid_q(result_valid_q), .conv_busy_q(conv_busy_q), .conv_aborted_q(conv_aborted_q),
  .span_double_q(span_double_q), .twos_comp_q(twos_comp_q), .power_state_q(power_state_q),
  .input_config_q(input_config_q), .power_down_q(power_down_q));
`default_nettype wire

//--- adcseq_host.sv
`default_nettype none
module adcseq_host (
  // Clock
  input wire logic clk,
  // Processor bus and conversion clock
  output logic conversion_start_n,
  output logic write_n,
  output logic [11:0] data_bus_bits,
  output logic conversion_clock_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int half = 2; // Half period of the conversion clock, raised for slow runs
  initial
  begin
    conversion_start_n = 1'b1;
    write_n = 1'b1;
    data_bus_bits = 12'h000;
    conversion_clock_in = 1'b0;
  end
  // Data held past the taking edge, then scrambled so stale data never matches
  task automatic write_word(input logic [11:0] w);
    @(posedge clk);
    write_n <= 1'b0;
    data_bus_bits <= w;
    repeat (2) @(posedge clk);
    write_n <= 1'b1;
    repeat (2) @(posedge clk);
    data_bus_bits <= ~w;
  endtask : write_word
  // Start pulse, then n periods; clock stands low outside conversions
  task automatic convert(input int n);
    @(posedge clk);
    conversion_start_n <= 1'b0;
    repeat (2) @(posedge clk);
    conversion_start_n <= 1'b1;
    repeat (n)
    begin
      repeat (half) @(posedge clk);
      conversion_clock_in <= 1'b1;
      repeat (half) @(posedge clk);
      conversion_clock_in <= 1'b0;
    end
    repeat (6) @(posedge clk);
  endtask : convert
  // Late abort followed by a write before any start rise or clock fall
  task automatic late_write(input logic [11:0] w);
    @(posedge clk);
    conversion_clock_in <= 1'b1;
    repeat (2) @(posedge clk);
    conversion_start_n <= 1'b0;
    write_word(w);
    conversion_start_n <= 1'b1;
    conversion_clock_in <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : late_write
endmodule : adcseq_host
`default_nettype wire

//--- adc_channel_sequencer_bench.sv
`default_nettype none
module adc_channel_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [11:0] ctl;
    logic [11:0] code;
    logic [2:0] chan;
    logic [11:0] res;
  } adcseq_row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] sample_code = 12'h000;
  wire logic conversion_start_n;
  wire logic write_n;
  wire logic [11:0] data_bus_bits;
  wire logic conversion_clock_in;
  wire logic [11:0] conv_result_q;
  wire logic [2:0] result_channel_q;
  wire logic [2:0] active_channel_q;
  wire logic [1:0] power_state_q;
  wire logic [1:0] input_config_q;
  wire logic result_valid_q, conv_busy_q, conv_aborted_q, span_double_q;
  wire logic twos_comp_q, power_down_q, seq_guard_miss_q;
  int fail_count = 0;
  int check_count = 0;
  int valid_cnt = 0;
  int abort_cnt = 0;
  int miss_cnt = 0;
  // Control word, front-end code, expected channel and result
  adcseq_row_t rows [6] = '{'{12'h000, 12'h123, 3'h0, 12'h123},
    '{12'h305, 12'h123, 3'h3, 12'h923}, '{12'h710, 12'hfff, 3'h7, 12'hfff},
    '{12'h5e4, 12'h800, 3'h5, 12'h000}, '{12'h441, 12'h001, 3'h4, 12'h001},
    '{12'h280, 12'h7ff, 3'h2, 12'h7ff}};
  always #5 clk = ~clk;
  adcseq_host adcseq_host_i (.clk(clk), .conversion_start_n(conversion_start_n),
    .write_n(write_n), .data_bus_bits(data_bus_bits), .conversion_clock_in(conversion_clock_in));
  adcseq_top adcseq_top_i (.clk(clk), .nrst(nrst), .conversion_start_n(conversion_start_n),
    .write_n(write_n), .data_bus_bits(data_bus_bits), .conversion_clock_in(conversion_clock_in),
    .sample_code(sample_code), .conv_result_q(conv_result_q), .result_channel_q(result_channel_q),
    .result_valid_q(result_valid_q), .conv_busy_q(conv_busy_q), .conv_aborted_q(conv_aborted_q),
    .active_channel_q(active_channel_q), .span_double_q(span_double_q), .twos_comp_q(twos_comp_q),
    .power_state_q(power_state_q), .input_config_q(input_config_q), .power_down_q(power_down_q),
    .seq_guard_miss_q(seq_guard_miss_q));
  // One-cycle pulses are counted here so tests can look later
  always @(posedge clk)
  begin
    valid_cnt += int'(result_valid_q === 1'b1);
    abort_cnt += int'(conv_aborted_q === 1'b1);
    miss_cnt += int'(seq_guard_miss_q === 1'b1);
  end
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Channels listed low nibble first
  task automatic run_seq(input logic [31:0] list, input int n, input logic [11:0] res);
    for (int i = 0; i < n; i++)
    begin
      adcseq_host_i.convert(13);
      check("channel", {9'h000, list[4*i +: 3]}, {9'h000, result_channel_q});
      check("active", {9'h000, list[4*i +: 3]}, {9'h000, active_channel_q});
      check("result", res, conv_result_q);
    end
  endtask : run_seq
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // Tests take under two thousand cycles; this margin is generous
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("BAD watchdog expected finish seen timeout");
    wrap_up();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i])
    begin
      sample_code <= rows[i].code;
      adcseq_host_i.write_word(rows[i].ctl);
      run_seq({29'h0, rows[i].chan}, 1, rows[i].res);
      check("fields", {6'h0, rows[i].ctl[0], rows[i].ctl[2], rows[i].ctl[5:4], rows[i].ctl[7:6]},
        {6'h0, span_double_q, twos_comp_q, power_state_q, input_config_q});
      check("power down", {11'h0, |rows[i].ctl[5:4]}, {11'h0, power_down_q});
    end
    $display("rows done");
    sample_code <= 12'h0c0;
    adcseq_host_i.write_word(12'h008);
    adcseq_host_i.write_word(12'h0a4);
    run_seq(32'h52, 2, 12'h0c0);
    adcseq_host_i.write_word(12'h006);
    run_seq(32'h27, 2, 12'h8c0);
    adcseq_host_i.write_word(12'h100);
    run_seq(32'h1, 1, 12'h0c0);
    adcseq_host_i.write_word(12'h0a4);
    run_seq(32'h0, 1, 12'h8c0);
    $display("mask sequence done");
    adcseq_host_i.write_word(12'h30a);
    run_seq(32'h03210, 5, 12'h0c0);
    adcseq_host_i.write_word(12'h088);
    adcseq_host_i.write_word(12'h00f);
    run_seq(32'h020, 3, 12'h0c0);
    $display("consecutive and pair done");
    valid_cnt = 0;
    abort_cnt = 0;
    adcseq_host_i.convert(12);
    check("early valid", 12'h000, 12'(valid_cnt));
    adcseq_host_i.half = 5;
    adcseq_host_i.convert(13);
    check("abort count", 12'h001, 12'(abort_cnt));
    check("valid count", 12'h001, 12'(valid_cnt));
    adcseq_host_i.convert(12);
    adcseq_host_i.late_write(12'h000);
    check("guard miss", 12'h001, 12'(miss_cnt));
    adcseq_host_i.write_word(12'h030);
    repeat (3) @(posedge clk);
    check("shutdown", 12'h001, {11'h0, power_down_q});
    $display("abort and power done");
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    check("after reset", 12'h000, {7'h0, conv_busy_q, power_state_q, power_down_q, 1'b0});
    run_seq(32'h0, 1, 12'h0c0);
    $display("reset done");
    wrap_up();
  end
endmodule : adc_channel_sequencer_bench
`default_nettype wire
